// File: hw/nfcai_seq.sv
// active initiator sequencer: framing, field switching, timers
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
// Operation
// - after transmit, parse receiver for reply start
// - check start byte, store length and data
// - trailing crc checked internally, not stored
// - wrong start byte: store anyway, soft error
// - bit clock fc/128, fc/64, fc/32 both ways
// - preset enables amplitude channel, disables phase
// - preset also sets transport frame enable
// - transport frame used at every rate
// - active mode sets field detector enable
// - peer threshold, avoidance threshold during field-on
// - transmitter enable set only by field-on
// - field off after general timer after tx
// - initial field-on: no field, on, guard, done
// - field off starts no-response timer
// - target field: event, mask timer, then receive
// - target off: event, auto avoidance, guard, done
// - tx: start byte, count+1, data, crc
module nfcai_seq #(
	parameter int IRFG_CYCLES = nfcai_pkg::IRFG_CYC,
	parameter int ARFG_CYCLES = nfcai_pkg::ARFG_CYC,
	parameter int DEPTH = 96
) (
	input wire logic clk,
	input wire logic rst,
	input wire nfcai_pkg::nfcai_bus_t bus,
	output logic [31:0] rdata,
	input wire logic ext_field_peer, // detector, peer threshold
	input wire logic ext_field_ca, // detector, avoidance threshold
	input wire nfcai_pkg::nfcai_byte_t rx_byte, // demodulated bytes
	input wire logic rx_sof, // receiver start of frame
	input wire logic rx_eof, // receiver end of frame
	output logic rx_enable, // receiver observing
	output logic ca_threshold_sel, // 1 = avoidance threshold
	output logic tx_en, // rf field on
	output logic tx_bit, // coded bit to modulator
	output logic bit_tick, // bit clock strobe
	output logic am_channel_en,
	output logic pm_channel_en,
	output logic field_det_en,
	output logic [15:0] rx_fifo_count
);
	import nfcai_pkg::*;

	// ------------------------------------------------------------
	// synchronisers for pin inputs
	// ------------------------------------------------------------
	logic [1:0] peer_s_q, ca_s_q; // two stages each
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			peer_s_q <= 2'h0;
			ca_s_q <= 2'h0;
		end else begin
			peer_s_q <= {peer_s_q[0], ext_field_peer};
			ca_s_q <= {ca_s_q[0], ext_field_ca};
		end
	end
	wire peer_field = peer_s_q[1];
	wire ca_field = ca_s_q[1];

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [31:0] ctrl_q; // mode and enables
	logic [15:0] txcnt_q, gpt_q, nrt_q, mrt_q; // counts and timers
	logic [ST_W-1:0] status_q; // sticky events
	logic [ST_W-1:0] set_ev; // events raised this cycle
	nfcai_state_t state_q;
	logic preset_go, init_go, resp_go, tx_go;

	assign preset_go = bus.wr && bus.addr == REG_CMD
		&& bus.wdata[7:0] == CMD_PRESET;
	assign init_go = bus.wr && bus.addr == REG_CMD
		&& bus.wdata[7:0] == CMD_INIT_ON;
	assign resp_go = bus.wr && bus.addr == REG_CMD
		&& bus.wdata[7:0] == CMD_RESP_ON;
	assign tx_go = bus.wr && bus.addr == REG_CMD
		&& bus.wdata[7:0] == CMD_TRANSMIT;

	// control register with hardware side effects
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= CTRL_RESET;
		end else begin
			if (bus.wr && bus.addr == REG_CTRL) begin
				ctrl_q <= bus.wdata;
				// active mode forces the detector on
				if (bus.wdata[CTRL_ACTIVE]) begin
					ctrl_q[CTRL_FDE] <= 1'b1;
				end
			end
			if (preset_go) begin
				ctrl_q[CTRL_AM] <= 1'b1;
				ctrl_q[CTRL_PM] <= 1'b0;
				ctrl_q[CTRL_TF106] <= 1'b1;
			end
		end
	end

	// plain value registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			txcnt_q <= 16'h0000;
			gpt_q <= 16'h0000;
			nrt_q <= 16'h0000;
			mrt_q <= 16'h0000;
		end else if (bus.wr) begin
			case (bus.addr)
				REG_TXCNT: txcnt_q <= bus.wdata[15:0];
				REG_GPT: gpt_q <= bus.wdata[15:0];
				REG_NRT: nrt_q <= bus.wdata[15:0];
				REG_MRT: mrt_q <= bus.wdata[15:0];
				default: ;
			endcase
		end
	end

	// sticky status: set beats a write-one clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			status_q <= '0;
		end else begin
			if (bus.wr && bus.addr == REG_STATUS) begin
				status_q <= (status_q & ~bus.wdata[ST_W-1:0]) | set_ev;
			end else begin
				status_q <= status_q | set_ev;
			end
		end
	end

	assign am_channel_en = ctrl_q[CTRL_AM];
	assign pm_channel_en = ctrl_q[CTRL_PM];
	assign field_det_en = ctrl_q[CTRL_FDE];

	// ------------------------------------------------------------
	// bit clock divider
	// ------------------------------------------------------------
	function automatic logic [7:0] rate_div(input logic [1:0] r);
		case (r)
			2'h1: rate_div = DIV_212;
			2'h2: rate_div = DIV_424;
			default: rate_div = DIV_106;
		endcase
	endfunction
	logic [7:0] div_q;
	// same divider for tx and rx, selected rate
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_q <= 8'h00;
		end else if (div_q >= rate_div(ctrl_q[CTRL_RATE+:2]) - 8'h01) begin
			div_q <= 8'h00;
		end else begin
			div_q <= div_q + 8'h01;
		end
	end
	assign bit_tick = div_q == 8'h00;

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	logic [31:0] tmr_q; // shared phase timer
	logic peer_d_q; // previous peer field level
	logic tx_done; // serializer finished
	logic auto_on; // automatic response armed
	assign auto_on = ctrl_q[CTRL_AR];
	logic resp_mode_q; // guard uses response time

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			peer_d_q <= 1'b0;
		end else begin
			peer_d_q <= peer_field;
		end
	end

	// state, timer, field enable
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= S_IDLE;
			tmr_q <= 32'h0;
			tx_en <= 1'b0;
			resp_mode_q <= 1'b0;
		end else begin
			tmr_q <= tmr_q + 32'h1;
			case (state_q)
				S_IDLE: begin
					if (init_go || resp_go) begin
						state_q <= S_CA;
						resp_mode_q <= resp_go;
						tmr_q <= 32'h0;
					end
				end
				S_CA: begin
					if (ca_field) begin
						state_q <= S_IDLE; // collision, stay off
					end else if (tmr_q >= CA_CYC - 1) begin
						tx_en <= 1'b1;
						state_q <= S_GUARD;
						tmr_q <= 32'h0;
					end
				end
				S_GUARD: begin
					if (tmr_q >= (resp_mode_q ? ARFG_CYCLES : IRFG_CYCLES) - 1)
						begin
						state_q <= S_FIELD_ON;
					end
				end
				S_FIELD_ON: begin
					if (tx_go) begin
						state_q <= S_TX;
					end
				end
				S_TX: begin
					if (tx_done) begin
						state_q <= S_HOLD;
						tmr_q <= 32'h0;
					end
				end
				S_HOLD: begin
					if (tmr_q >= {16'h0, gpt_q}) begin
						tx_en <= 1'b0;
						state_q <= S_WAIT_FIELD;
						tmr_q <= 32'h0;
					end
				end
				S_WAIT_FIELD: begin
					if (peer_field && !peer_d_q) begin
						state_q <= S_MASK;
						tmr_q <= 32'h0;
					end else if (tmr_q >= {16'h0, nrt_q}) begin
						state_q <= S_IDLE;
					end
				end
				S_MASK: begin
					if (tmr_q >= {16'h0, mrt_q}) begin
						state_q <= S_RX;
					end
				end
				S_RX: begin
					if (!peer_field && peer_d_q) begin
						// loop back into avoidance while armed
						state_q <= auto_on ? S_CA : S_IDLE;
						resp_mode_q <= 1'b1;
						tmr_q <= 32'h0;
					end
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end
	assign ca_threshold_sel = state_q == S_CA;
	assign rx_enable = state_q == S_RX;

	// ------------------------------------------------------------
	// transmit serializer: start, length, fifo data, crc
	// ------------------------------------------------------------
	function automatic logic [15:0] crc_byte(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		crc_byte = r;
	endfunction

	logic [7:0] fifo_mem [DEPTH];
	logic [15:0] wr_ptr_q, rd_ptr_q, tx_idx_q;
	logic [2:0] bit_q;
	logic [15:0] tx_crc_q;
	logic [7:0] cur_byte;
	logic tx_last_bit;

	// byte order: F0, count+1, data..., crc lo, crc hi
	always_comb begin
		if (tx_idx_q == 16'h0) cur_byte = START_BYTE;
		else if (tx_idx_q == 16'h1) cur_byte = txcnt_q[7:0] + 8'h01;
		else if (tx_idx_q < txcnt_q + 16'h2)
			cur_byte = fifo_mem[rd_ptr_q % DEPTH];
		else if (tx_idx_q == txcnt_q + 16'h2) cur_byte = tx_crc_q[7:0];
		else cur_byte = tx_crc_q[15:8];
	end
	assign tx_last_bit = bit_q == 3'h7 && tx_idx_q == txcnt_q + 16'h3;
	assign tx_done = state_q == S_TX && bit_tick && tx_last_bit;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_idx_q <= 16'h0;
			bit_q <= 3'h0;
			tx_crc_q <= CRC_INIT;
			tx_bit <= 1'b0;
		end else if (state_q != S_TX) begin
			tx_idx_q <= 16'h0;
			bit_q <= 3'h0;
			tx_crc_q <= CRC_INIT;
			tx_bit <= 1'b0;
		end else if (bit_tick) begin
			tx_bit <= cur_byte[bit_q]; // lsb first
			bit_q <= bit_q + 3'h1;
			if (bit_q == 3'h7) begin
				tx_idx_q <= tx_idx_q + 16'h1;
				if (tx_idx_q < txcnt_q + 16'h2)
					tx_crc_q <= crc_byte(tx_crc_q, cur_byte);
			end
		end
	end

	// ------------------------------------------------------------
	// receive framing: start check, store, crc hold-back
	// ------------------------------------------------------------
	logic [15:0] rx_idx_q, rx_crc_q;
	logic [15:0] hold_q; // last two bytes held back
	logic [1:0] hold_n_q;
	logic fifo_push; // byte leaves the hold-back stage
	logic fifo_pop; // serializer consumed a byte
	assign fifo_push = rx_enable && rx_byte.valid && rx_idx_q != 16'h0
		&& hold_n_q == 2'h2;
	assign fifo_pop = state_q == S_TX && bit_tick && bit_q == 3'h7
		&& tx_idx_q >= 16'h2 && tx_idx_q < txcnt_q + 16'h2;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_idx_q <= 16'h0;
			rx_crc_q <= CRC_INIT;
			hold_q <= 16'h0;
			hold_n_q <= 2'h0;
		end else if (!rx_enable || rx_sof) begin
			rx_idx_q <= 16'h0;
			rx_crc_q <= CRC_INIT;
			hold_n_q <= 2'h0;
		end else if (rx_byte.valid) begin
			rx_idx_q <= rx_idx_q + 16'h1;
			rx_crc_q <= crc_byte(rx_crc_q, rx_byte.data);
			if (rx_idx_q != 16'h0) begin
				// trailing two bytes never reach the fifo
				hold_q <= {hold_q[7:0], rx_byte.data};
				if (hold_n_q != 2'h2) hold_n_q <= hold_n_q + 2'h1;
			end
		end
	end

	// shared byte store: rx writes, tx reads
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr_q <= 16'h0;
			rd_ptr_q <= 16'h0;
		end else begin
			if (fifo_push) begin
				wr_ptr_q <= wr_ptr_q + 16'h1;
			end
			if (fifo_pop) begin
				rd_ptr_q <= rd_ptr_q + 16'h1;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (fifo_push) fifo_mem[wr_ptr_q % DEPTH] <= hold_q[15:8];
	end
	assign rx_fifo_count = wr_ptr_q - rd_ptr_q;

	// event collection
	always_comb begin
		set_ev = '0;
		set_ev[ST_CAT] = state_q == S_GUARD && tmr_q
			>= (resp_mode_q ? ARFG_CYCLES : IRFG_CYCLES) - 1;
		set_ev[ST_CAC] = state_q == S_CA && ca_field;
		set_ev[ST_NRE] = state_q == S_WAIT_FIELD && !(peer_field
			&& !peer_d_q) && tmr_q >= {16'h0, nrt_q};
		set_ev[ST_EON] = state_q == S_WAIT_FIELD && peer_field
			&& !peer_d_q;
		set_ev[ST_EOF] = state_q == S_RX && !peer_field && peer_d_q;
		set_ev[ST_SOFT] = rx_enable && rx_byte.valid
			&& rx_idx_q == 16'h0 && rx_byte.data != START_BYTE;
		set_ev[ST_CRC] = rx_enable && rx_eof && rx_crc_q != 16'h0;
		set_ev[ST_RXE] = rx_enable && rx_eof;
		set_ev[ST_TXE] = tx_done;
	end

	// read data, one cycle after the strobe
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= 32'h0;
		end else if (bus.rd) begin
			case (bus.addr)
				REG_CTRL: rdata <= ctrl_q;
				REG_STATUS: rdata <= {{(32-ST_W){1'b0}}, status_q};
				REG_TXCNT: rdata <= {16'h0, txcnt_q};
				REG_GPT: rdata <= {16'h0, gpt_q};
				REG_NRT: rdata <= {16'h0, nrt_q};
				REG_MRT: rdata <= {16'h0, mrt_q};
				REG_STATE: rdata <= {15'h0, tx_en, rx_fifo_count};
				default: rdata <= 32'h0;
			endcase
		end else begin
			rdata <= 32'h0;
		end
	end
endmodule

// File: include/nfcai_pkg.sv
// constants and carrier types for the active initiator sequencer
package nfcai_pkg;
	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00; // mode and enable bits
	localparam logic [7:0] REG_CMD = 8'h04; // direct command (write)
	localparam logic [7:0] REG_STATUS = 8'h08; // sticky events, write 1 clears
	localparam logic [7:0] REG_TXCNT = 8'h0C; // transmit byte count
	localparam logic [7:0] REG_GPT = 8'h10; // field hold after tx, cycles
	localparam logic [7:0] REG_NRT = 8'h14; // no-response time, cycles
	localparam logic [7:0] REG_MRT = 8'h18; // mask receive time, cycles
	localparam logic [7:0] REG_STATE = 8'h1C; // field enable and fifo count readback
	// ------------------------------------------------------------
	// control fields
	// ------------------------------------------------------------
	localparam int CTRL_ACTIVE = 0; // active communication mode
	localparam int CTRL_TARG = 1; // target-mode select, keep 0
	localparam int CTRL_AR = 2; // auto_response_avoidance_en
	localparam int CTRL_N0 = 3; // response_avoid_count_lo
	localparam int CTRL_N1 = 4; // response_avoid_count_hi
	localparam int CTRL_FDE = 5; // field_detector_enable
	localparam int CTRL_TF106 = 6; // transport_frame_106_enable
	localparam int CTRL_AM = 7; // amplitude channel enable
	localparam int CTRL_PM = 8; // phase channel enable
	localparam int CTRL_RATE = 9; // two bits: 0=106 1=212 2=424
	localparam logic [31:0] CTRL_RESET = 32'h00000000;
	// ------------------------------------------------------------
	// direct commands
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_PRESET = 8'h01; // analog preset
	localparam logic [7:0] CMD_INIT_ON = 8'h02; // initial field on
	localparam logic [7:0] CMD_RESP_ON = 8'h03; // response field on
	localparam logic [7:0] CMD_TRANSMIT = 8'h04; // transmit with crc
	// ------------------------------------------------------------
	// status bits
	// ------------------------------------------------------------
	localparam int ST_CAT = 0; // avoidance done, field on
	localparam int ST_CAC = 1; // collision detected
	localparam int ST_NRE = 2; // no-response timeout
	localparam int ST_EON = 3; // target field on
	localparam int ST_EOF = 4; // target field off
	localparam int ST_SOFT = 5; // soft framing error
	localparam int ST_CRC = 6; // crc error
	localparam int ST_RXE = 7; // frame received
	localparam int ST_TXE = 8; // transmit done
	localparam int ST_W = 9;
	// ------------------------------------------------------------
	// framing and timing
	// ------------------------------------------------------------
	localparam logic [7:0] START_BYTE = 8'hF0;
	localparam logic [15:0] CRC_INIT = 16'h6363;
	localparam logic [15:0] CRC_POLY = 16'h8408;
	localparam logic [7:0] DIV_106 = 8'h80; // fc/128
	localparam logic [7:0] DIV_212 = 8'h40; // fc/64
	localparam logic [7:0] DIV_424 = 8'h20; // fc/32
	localparam int CLK_MHZ = 50;
	localparam int IRFG_US = 5100; // initial_guard_time, us
	localparam int ARFG_US = 1024; // response_guard_time, us
	localparam int IRFG_CYC = IRFG_US * CLK_MHZ;
	localparam int ARFG_CYC = ARFG_US * CLK_MHZ;
	localparam int CA_CYC = 64; // avoidance observation window
	// ------------------------------------------------------------
	// carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} nfcai_bus_t;
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} nfcai_byte_t;
	typedef enum {
		S_IDLE, S_CA, S_GUARD, S_FIELD_ON, S_TX, S_HOLD,
		S_WAIT_FIELD, S_MASK, S_RX
	} nfcai_state_t;
endpackage

// File: verif/nfcai_monitor.sv
// port checker for the active initiator sequencer
`timescale 1ns/1ps
module nfcai_monitor (
	input wire logic clk,
	input wire logic rst,
	input wire nfcai_pkg::nfcai_bus_t bus,
	input wire logic ext_field_peer,
	input wire nfcai_pkg::nfcai_byte_t rx_byte,
	input wire logic rx_enable,
	input wire logic ca_threshold_sel,
	input wire logic tx_en,
	input wire logic am_channel_en,
	input wire logic pm_channel_en,
	input wire logic field_det_en,
	input wire logic [15:0] rx_fifo_count
);
	import nfcai_pkg::*;
	// ----
	// avoidance run length
	// ----
	logic [7:0] ca_cnt_q; // cycles on the avoidance threshold
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// saturates so a long avoidance run cannot wrap it back to zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ca_cnt_q <= 8'h00;
		end else if (!ca_threshold_sel) begin
			ca_cnt_q <= 8'h00;
		end else if (ca_cnt_q != 8'hFF) begin
			ca_cnt_q <= ca_cnt_q + 8'h01;
		end
	end
	// ----
	// assertions
	// ----
	field_det_on_a: assert property (bus.wr && bus.addr == REG_CTRL &&
		bus.wdata[CTRL_ACTIVE] |=> field_det_en)
		else $error("detector not enabled by active mode");
	preset_am_a: assert property (bus.wr && bus.addr == REG_CMD &&
		bus.wdata[7:0] == CMD_PRESET |-> ##[1:3] (am_channel_en &&
		!pm_channel_en)) else $error("preset channels wrong");
	field_by_cmd_a: assert property ($rose(tx_en) |->
		$past(ca_threshold_sel)) else $error("field on outside command");
	ca_window_a: assert property ($rose(tx_en) |->
		ca_cnt_q >= 8'h20) else $error("avoidance window too short");
	ca_start_a: assert property ($rose(ca_threshold_sel) |->
		!tx_en) else $error("avoidance with own field on");
	rx_field_off_a: assert property (tx_en |-> !rx_enable)
		else $error("receiving while field on");
	rx_after_peer_a: assert property ($rose(rx_enable) |->
		ext_field_peer) else $error("receive without target field");
	// the transmitter drains the store only while the field is on
	fifo_step_a: assert property (!tx_en &&
		rx_fifo_count != $past(rx_fifo_count)
		|-> ($past(rx_byte.valid) || $past(rx_byte.valid, 2)) &&
		rx_fifo_count == $past(rx_fifo_count) + 16'h0001)
		else $error("fifo grew without a byte");
endmodule

bind nfcai_seq nfcai_monitor mon_u (.clk(clk), .rst(rst), .bus(bus),
	.ext_field_peer(ext_field_peer), .rx_byte(rx_byte),
	.rx_enable(rx_enable), .ca_threshold_sel(ca_threshold_sel),
	.tx_en(tx_en), .am_channel_en(am_channel_en),
	.pm_channel_en(pm_channel_en), .field_det_en(field_det_en),
	.rx_fifo_count(rx_fifo_count));

// File: verif/nfcai_peer_model.sv
// behavioural active target: field, receiver bytes, frame crc
`timescale 1ns/1ps
module nfcai_peer_model (
	input wire logic clk,
	input wire logic tx_en,
	input wire logic rx_enable,
	input wire logic reply_en,
	input wire logic jam,
	input wire logic [7:0] first_byte,
	output logic ext_field_peer,
	output logic ext_field_ca,
	output nfcai_pkg::nfcai_byte_t rx_byte,
	output logic rx_sof,
	output logic rx_eof
);
	import nfcai_pkg::*;
	logic field_q; // own rf field
	// jam is a foreign field seen by both thresholds
	assign ext_field_peer = field_q | jam;
	assign ext_field_ca = field_q | jam;
	// reflected crc, low byte sent first
	function automatic logic [15:0] crc_add(logic [15:0] c, logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			c = (c[0] ^ b[i]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction
	// one byte pulse, then the data lines show the inverse
	task automatic send(input logic [7:0] b);
		@(posedge clk);
		rx_byte <= '{valid: 1'b1, data: b};
		@(posedge clk);
		rx_byte <= '{valid: 1'b0, data: ~b};
		repeat (2) @(posedge clk);
	endtask
	// reply after each drop of the initiator field while reply_en is high
	initial begin
		logic [15:0] crc;
		logic [7:0] f [4];
		f = '{8'h04, 8'hA1, 8'hA2, 8'hA3}; // length is data count + 1
		field_q = 1'b0;
		rx_byte = '{valid: 1'b0, data: 8'h00};
		rx_sof = 1'b0;
		rx_eof = 1'b0;
		forever begin
			@(negedge tx_en);
			if (reply_en) begin
				repeat (10) @(posedge clk);
				field_q <= 1'b1;
				for (int k = 0; k < 400 && !rx_enable; k++) @(posedge clk);
				@(posedge clk);
				rx_sof <= 1'b1;
				@(posedge clk);
				rx_sof <= 1'b0;
				send(first_byte);
				// the frame crc covers the start byte as well
				crc = crc_add(CRC_INIT, first_byte);
				for (int i = 0; i < 4; i++) begin
					crc = crc_add(crc, f[i]);
					send(f[i]);
				end
				send(crc[7:0]);
				send(crc[15:8]);
				rx_eof <= 1'b1;
				@(posedge clk);
				rx_eof <= 1'b0;
				repeat (8) @(posedge clk);
				field_q <= 1'b0;
			end
		end
	end
endmodule

// File: verif/nfcai_seq_tb.sv
// self-checking bench for the active initiator sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
	n_mismatch++; \
	$display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); \
end end
module nfcai_seq_tb;
	import nfcai_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	nfcai_bus_t bus;
	logic [31:0] rdata, d, ctrl;
	logic pk, ck, sof, eof, rxen, cas, tx_en, txb, bit_tick, am, pm, fde;
	nfcai_byte_t rxb;
	logic [15:0] rx_fifo_count, base;
	logic reply_en, jam;
	logic [7:0] first_byte;
	int n_mismatch = 0;
	int tests_run = 0;
	int n;
	always #10 clk = ~clk;
	nfcai_seq #(.IRFG_CYCLES(20), .ARFG_CYCLES(20)) dut_u (.clk(clk),
		.rst(rst), .bus(bus), .rdata(rdata), .ext_field_peer(pk),
		.ext_field_ca(ck), .rx_byte(rxb), .rx_sof(sof), .rx_eof(eof),
		.rx_enable(rxen), .ca_threshold_sel(cas), .tx_en(tx_en),
		.tx_bit(txb), .bit_tick(bit_tick), .am_channel_en(am),
		.pm_channel_en(pm), .field_det_en(fde),
		.rx_fifo_count(rx_fifo_count));
	nfcai_peer_model partner_u (.clk(clk), .tx_en(tx_en), .rx_enable(rxen),
		.reply_en(reply_en), .jam(jam), .first_byte(first_byte),
		.ext_field_peer(pk), .ext_field_ca(ck), .rx_byte(rxb),
		.rx_sof(sof), .rx_eof(eof));
	// ----
	// bus tasks
	// ----
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask
	// data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '0;
		@(posedge clk);
		v = rdata;
	endtask
	// poll a sticky event, then clear it by writing one
	task automatic wait_st(input int b, input int tries);
		d = '0;
		for (int k = 0; k < tries && d[b] !== 1'b1; k++) rd(REG_STATUS, d);
		`CHK(d[b], 1'b1)
		wr(REG_STATUS, 32'h1 << b);
	endtask
	// cycles between two bit strobes
	task automatic gap(output int g);
		for (int k = 0; k < 300 && bit_tick !== 1'b1; k++) @(posedge clk);
		g = 0;
		do begin
			@(posedge clk);
			g++;
		end while (bit_tick !== 1'b1 && g < 300);
	endtask
	// first two frame bytes off tx_bit, lsb first
	task automatic tx_head(output logic [15:0] v);
		int t;
		t = 0;
		v = '0;
		while (t < 17) begin
			@(negedge clk);
			if (bit_tick === 1'b1) begin
				if (t > 0) v = {txb, v[15:1]};
				t++;
			end
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// watchdog: the exchanges need well under this many cycles
	initial begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		print_verdict();
	end
	// ----
	// test sequence
	// ----
	initial begin
		bus = '0;
		reply_en = 1'b0;
		jam = 1'b0;
		first_byte = START_BYTE;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(REG_CTRL, d);
		`CHK(d, CTRL_RESET)
		rd(8'hFC, d);
		`CHK(d, 32'h00000000)
		wr(REG_GPT, 32'd16);
		wr(REG_NRT, 32'd200);
		wr(REG_MRT, 32'd20);
		wr(REG_TXCNT, 32'd3);
		// active initiator, auto response, count bits kept at zero
		wr(REG_CTRL, (32'h1 << CTRL_ACTIVE) | (32'h1 << CTRL_AR));
		@(negedge clk);
		`CHK(fde, 1'b1)
		wr(REG_CMD, {24'h0, CMD_PRESET});
		rd(REG_CTRL, ctrl);
		`CHK(ctrl[CTRL_TF106], 1'b1)
		`CHK({ctrl[CTRL_AM], ctrl[CTRL_PM], am, pm}, 4'hA)
		for (int r = 0; r < 3; r++) begin
			wr(REG_CTRL, ctrl | (r << CTRL_RATE));
			gap(n);
			`CHK(n, 128 >> r)
		end
		wr(REG_CTRL, ctrl);
		// a foreign field blocks the initial field on
		jam <= 1'b1;
		wr(REG_CMD, {24'h0, CMD_INIT_ON});
		wait_st(ST_CAC, 60);
		`CHK(tx_en, 1'b0)
		jam <= 1'b0;
		// silent target: field drops, then no-response timeout
		wr(REG_CMD, {24'h0, CMD_INIT_ON});
		wait_st(ST_CAT, 60);
		`CHK(tx_en, 1'b1)
		wr(REG_CMD, {24'h0, CMD_TRANSMIT});
		// start byte, then length of three data bytes plus one
		tx_head(base);
		`CHK(base, {8'h04, START_BYTE})
		wait_st(ST_TXE, 4000);
		n = 0;
		while (tx_en === 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		`CHK(n <= 16, 1'b1)
		wait_st(ST_NRE, 100);
		rd(REG_STATUS, d);
		`CHK(d[ST_EON], 1'b0)
		// answering target: good, bad start, then last exchange
		reply_en <= 1'b1;
		wr(REG_CMD, {24'h0, CMD_INIT_ON});
		wait_st(ST_CAT, 60);
		for (int x = 0; x < 3; x++) begin
			first_byte <= (x == 1) ? 8'h5A : START_BYTE;
			if (x == 2) wr(REG_CTRL, ctrl & ~(32'h1 << CTRL_AR));
			wr(REG_CMD, {24'h0, CMD_TRANSMIT});
			wait_st(ST_EON, 4000);
			base = rx_fifo_count;
			wait_st(ST_RXE, 300);
			`CHK(rx_fifo_count - base, 16'h0004)
			rd(REG_STATUS, d);
			`CHK(d[ST_SOFT], x == 1)
			`CHK(d[ST_CRC], 1'b0)
			wr(REG_STATUS, 32'h1 << ST_SOFT);
			wait_st(ST_EOF, 60);
			if (x < 2) begin
				wait_st(ST_CAT, 60);
				`CHK(tx_en, 1'b1)
			end
		end
		repeat (100) @(posedge clk);
		rd(REG_STATUS, d);
		`CHK({tx_en, d[ST_CAT]}, 2'b00)
		// a response field on from idle ends with the field up
		wr(REG_CMD, {24'h0, CMD_RESP_ON});
		wait_st(ST_CAT, 60);
		`CHK(tx_en, 1'b1)
		print_verdict();
	end
endmodule
